// File: rtl/xpsc_regs.svh
`ifndef XPSC_REGS_SVH
`define XPSC_REGS_SVH

// ==================================================================
// matrix geometry
`define XPSC_NUM_OUT 8
`define XPSC_NUM_IN 16
`define XPSC_SEL_BITS 4
`define XPSC_OADDR_BITS 3

// ==================================================================
// frame layout, bit 0 is the first bit shifted in
`define XPSC_FRAME_BITS 40
`define XPSC_FIELD_BITS 5
`define XPSC_FIELD_SEL_LSB 0
`define XPSC_FIELD_OFF_BIT 4

// ==================================================================
// addressed word layout, the last 8 bits of the bank
`define XPSC_WORD_BITS 8
`define XPSC_WORD_LSB 32
`define XPSC_WORD_OADDR_LSB 0
`define XPSC_WORD_IADDR_LSB 3
`define XPSC_WORD_OFF_BIT 7

// ==================================================================
// reset values of the holding bank
`define XPSC_RST_SEL 4'h0
`define XPSC_RST_OE 1'b0

// ==================================================================
// timing
`define XPSC_CLK_SYS_MHZ 50
`define XPSC_T_CS_SETUP_NS 5
`define XPSC_CS_SETUP_CYC \
  (((`XPSC_T_CS_SETUP_NS * `XPSC_CLK_SYS_MHZ) + 999) / 1000)

`endif

// File: rtl/xpsc_pkg.sv
package xpsc_pkg;

  // ================================================================
  // types
  typedef logic [3:0] xpsc_sel_t;
  typedef logic [2:0] xpsc_oaddr_t;

  typedef enum logic {
    XPSC_MODE_FRAME = 1'b0,
    XPSC_MODE_ADDR = 1'b1
  } xpsc_mode_t;

endpackage

// File: rtl/xpsc_sync.sv
`timescale 1ns/100ps

module xpsc_sync
  import xpsc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic clk_sys,
  // async levels in, synchronised out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ================================================================
  // two flops per bit; first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic stab_q;
      always_ff @(posedge clk_sys) begin
        meta_q <= async_i[g];
      end
      always_ff @(posedge clk_sys) begin
        stab_q <= meta_q;
      end
      assign sync_o[g] = stab_q;
    end
  endgenerate

endmodule

// File: rtl/xpsc_shift.sv
`timescale 1ns/100ps
`include "xpsc_regs.svh"

module xpsc_shift
  import xpsc_pkg::*;
#(
  parameter int FRAME_BITS = `XPSC_FRAME_BITS
) (
  // link side
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_q,
  // towards the system side
  output logic [FRAME_BITS-1:0] bank_q,
  output logic shift_tgl_q,
  output logic armed_q
);

  // ================================================================
  // arming on rising edge; cs high disarms at the next one
  always_ff @(posedge sclk) begin
    armed_q <= ~cs_n; // see RULE3 RULE4
  end

  // ================================================================
  // shift bank, falling edge, first bit ends at index 0
  // no reset: the link clock may be stopped while srst is asserted
  always_ff @(negedge sclk) begin
    if (armed_q) begin
      bank_q <= {din, bank_q[FRAME_BITS-1:1]}; // see RULE2 RULE6 RULE4
    end
  end

  // displaced bits leave on the serial output
  always_ff @(negedge sclk) begin
    if (armed_q) begin
      dout_q <= bank_q[0]; // see RULE17
    end
  end

  // each shifted bit flips this, crossing as an event
  // power-up value only: with no link reset an unknown toggle would
  // hide every shift from the system side
  logic tgl_q = 1'b0;

  always_ff @(negedge sclk) begin
    if (armed_q) begin
      tgl_q <= ~tgl_q; // see RULE10
    end
  end

  assign shift_tgl_q = tgl_q;

  // ================================================================
  // checks on the link clock
  property p_shift_in;
    // older bits stay unknown until a frame has filled the bank
    @(negedge sclk) armed_q |=>
      bank_q[FRAME_BITS-1] == $past(din);
  endproperty
  a_shift_in: assert property (p_shift_in) // see RULE6
    else $error("bank did not take din on falling edge");

  property p_idle_hold;
    @(negedge sclk) !armed_q |=> $stable(bank_q) && $stable(shift_tgl_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) // see RULE3
    else $error("bank moved while not armed");

endmodule

// File: rtl/xpsc_ctrl.sv
// Summary of operation
// RULE1 - one holding register per output keeps enable and input address
// RULE2 - a shift bank of same content is loaded only through serial input
// RULE3 - with chip select high, data and clock activity are ignored
// RULE4 - first rising edge after select low arms; next falling edge captures
// RULE5 - host lowers chip select at least 5 ns before first rising edge
// RULE6 - every serial bit is sampled on a falling clock edge
// RULE7 - host raises select after last bit, then gives one more rising edge
// RULE8 - shifted data reaches the matrix only on a configure pulse
// RULE9 - configure and mode act regardless of chip select
// RULE10 - configure without new shifted data has no effect
// RULE11 - mode high: an addressed word updates only its named output
// RULE12 - mode low: a 40-bit frame programs all outputs
// RULE13 - an output whose enable is off goes high impedance
// RULE14 - any input feeds many outputs; each output has exactly one input
// RULE15 - frame is eight 5-bit fields, output 0 first, address then off bit
// RULE16 - word: bits 0-2 output, bits 3-6 input, bit 7 set means off
// RULE17 - clocking past valid data shifts on and pushes old bits out
// RULE18 - host moves select with clock low, configure low until shifted
// RULE19 - addressed configure touches only the named holding register
// RULE20 - serial clock runs the shift bank; configure rising edge loads
`timescale 1ns/100ps
`include "xpsc_regs.svh"

module xpsc_ctrl
  import xpsc_pkg::*;
#(
  parameter int NUM_OUT = `XPSC_NUM_OUT,
  parameter int SEL_BITS = `XPSC_SEL_BITS,
  parameter int FRAME_BITS = `XPSC_FRAME_BITS
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  // control pins
  input wire logic cfg,
  input wire logic mode,
  // matrix drive
  output logic [NUM_OUT*SEL_BITS-1:0] out_sel,
  output logic [NUM_OUT-1:0] out_oe,
  // status
  output logic data_pending,
  output logic load_done,
  output logic link_armed
);

  // ================================================================
  // declarations
  logic [FRAME_BITS-1:0] bank;
  logic shift_tgl;
  logic armed;
  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic cfg_s;
  logic tgl_s;
  logic cfg_prev_q;
  logic tgl_seen_q;
  logic cfg_rise;
  logic tgl_chg;
  logic pend_q;
  logic fire;
  xpsc_mode_t mode_s;
  logic [`XPSC_WORD_BITS-1:0] word;
  xpsc_oaddr_t word_oaddr;
  xpsc_sel_t word_iaddr;
  logic word_off;
  logic [NUM_OUT*SEL_BITS-1:0] sel_q;
  logic [NUM_OUT-1:0] oe_q;
  logic done_q;
  logic armed_s;
  logic mode_raw;

  // ================================================================
  // link side
  xpsc_shift #(
    .FRAME_BITS(FRAME_BITS)
  ) u_shift (
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout_q(dout),
    .bank_q(bank),
    .shift_tgl_q(shift_tgl),
    .armed_q(armed)
  );

  // ================================================================
  // crossing into the system clock
  // cfg and mode are taken without looking at cs_n
  assign sync_in = {armed, shift_tgl, cfg}; // see RULE9
  xpsc_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .async_i(sync_in),
    .sync_o(sync_out)
  );

  xpsc_sync #(
    .WIDTH(1)
  ) u_sync_mode (
    .clk_sys(clk_sys),
    .async_i(mode),
    .sync_o(mode_raw)
  );
  // the enum only ever takes a cast copy of the synced bit
  assign mode_s = xpsc_mode_t'(mode_raw);

  assign cfg_s = sync_out[0];
  assign tgl_s = sync_out[1];
  assign armed_s = sync_out[2];

  // ================================================================
  // edge and event detect
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_prev_q <= 1'b0;
    end else begin
      cfg_prev_q <= cfg_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_s;
    end
  end

  assign cfg_rise = cfg_s & ~cfg_prev_q; // see RULE20
  assign tgl_chg = tgl_s ^ tgl_seen_q;

  // ================================================================
  // new-data flag; a bit arriving with the load keeps it set
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pend_q <= 1'b0;
    end else if (tgl_chg) begin
      pend_q <= 1'b1;
    end else if (fire) begin
      pend_q <= 1'b0;
    end
  end

  // bank is quiet by now: the host holds cfg low until shifting ends
  assign fire = cfg_rise & pend_q; // see RULE8 RULE10 RULE18

  // ================================================================
  // addressed word fields
  assign word = bank[`XPSC_WORD_LSB +: `XPSC_WORD_BITS]; // see RULE16
  assign word_oaddr = word[`XPSC_WORD_OADDR_LSB +: 3];
  assign word_iaddr = word[`XPSC_WORD_IADDR_LSB +: 4];
  assign word_off = word[`XPSC_WORD_OFF_BIT];

  // ================================================================
  // holding bank, one register per output
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_hold
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          sel_q[g*SEL_BITS +: SEL_BITS] <= `XPSC_RST_SEL;
          oe_q[g] <= `XPSC_RST_OE;
        end else if (fire && mode_s == XPSC_MODE_FRAME) begin
          sel_q[g*SEL_BITS +: SEL_BITS] <= // see RULE12 RULE15
            bank[g*`XPSC_FIELD_BITS + `XPSC_FIELD_SEL_LSB +: SEL_BITS];
          oe_q[g] <= ~bank[g*`XPSC_FIELD_BITS + `XPSC_FIELD_OFF_BIT];
        end else if (fire && word_oaddr == xpsc_oaddr_t'(g)) begin
          sel_q[g*SEL_BITS +: SEL_BITS] <= word_iaddr; // see RULE11 RULE19
          oe_q[g] <= ~word_off;
        end
      end
    end
  endgenerate

  // one selector per output, so one input each; inputs may repeat
  assign out_sel = sel_q; // see RULE1 RULE14
  // off outputs drop their enable and float
  assign out_oe = oe_q; // see RULE13

  // ================================================================
  // status
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= fire;
    end
  end

  assign load_done = done_q;
  assign data_pending = pend_q;
  assign link_armed = armed_s;

  // ================================================================
  // checks on the system clock
  property p_no_new_no_load;
    @(posedge clk_sys) disable iff (srst)
      cfg_rise && !pend_q |=> $stable(sel_q) && $stable(oe_q);
  endproperty
  a_no_new_no_load: assert property (p_no_new_no_load) // see RULE10
    else $error("configure without new data changed matrix");

  property p_hold_without_cfg;
    @(posedge clk_sys) disable iff (srst)
      !fire |=> $stable(sel_q) && $stable(oe_q);
  endproperty
  a_hold_without_cfg: assert property (p_hold_without_cfg) // see RULE8
    else $error("matrix changed without configure pulse");

  property p_frame_load;
    @(posedge clk_sys) disable iff (srst)
      fire && mode_s == XPSC_MODE_FRAME |=>
        oe_q[0] == ~$past(bank[`XPSC_FIELD_OFF_BIT]) &&
        sel_q[SEL_BITS-1:0] == $past(bank[SEL_BITS-1:0]) &&
        oe_q[NUM_OUT-1] == ~$past(bank[FRAME_BITS-1]);
  endproperty
  a_frame_load: assert property (p_frame_load) // see RULE12
    else $error("frame load mismatch");

  // every field of a frame lands in its own output
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_chk
      property p_frame_field;
        @(posedge clk_sys) disable iff (srst)
          fire && mode_s == XPSC_MODE_FRAME |=>
            sel_q[g*SEL_BITS +: SEL_BITS] ==
              $past(bank[g*`XPSC_FIELD_BITS +: SEL_BITS]) &&
            oe_q[g] == ~$past(bank[g*`XPSC_FIELD_BITS + `XPSC_FIELD_OFF_BIT]);
      endproperty
      a_frame_field: assert property (p_frame_field) // see RULE15
        else $error("frame field landed on wrong output");
    end
  endgenerate

  property p_addr_target;
    @(posedge clk_sys) disable iff (srst)
      fire && mode_s == XPSC_MODE_ADDR |=>
        sel_q[$past(word_oaddr)*SEL_BITS +: SEL_BITS] == $past(word_iaddr)
        && oe_q[$past(word_oaddr)] == ~$past(word_off);
  endproperty
  a_addr_target: assert property (p_addr_target) // see RULE11
    else $error("addressed load missed its output");

  property p_addr_others;
    @(posedge clk_sys) disable iff (srst)
      fire && mode_s == XPSC_MODE_ADDR && word_oaddr != 3'h0 |=>
        $stable(sel_q[SEL_BITS-1:0]) && $stable(oe_q[0]);
  endproperty
  a_addr_others: assert property (p_addr_others) // see RULE19
    else $error("addressed load touched output 0");

  property p_pend_set;
    @(posedge clk_sys) disable iff (srst)
      tgl_chg |=> pend_q;
  endproperty
  a_pend_set: assert property (p_pend_set) // see RULE10
    else $error("new data not flagged");

  property p_pend_clear;
    @(posedge clk_sys) disable iff (srst)
      fire && !tgl_chg |=> !pend_q ##1 (!pend_q || $past(tgl_chg));
  endproperty
  a_pend_clear: assert property (p_pend_clear) // see RULE8
    else $error("pending flag not cleared by load");

  property p_done_pulse;
    @(posedge clk_sys) disable iff (srst)
      cfg_rise && pend_q |=> load_done ##1 !load_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) // see RULE20
    else $error("load_done not a one-cycle pulse after load");

  property p_pend_keep;
    @(posedge clk_sys) disable iff (srst)
      pend_q && !fire |=> pend_q;
  endproperty
  a_pend_keep: assert property (p_pend_keep) // see RULE10
    else $error("pending flag lost without a load");

  property p_done_cause;
    @(posedge clk_sys) disable iff (srst)
      !fire |=> !load_done;
  endproperty
  a_done_cause: assert property (p_done_cause) // see RULE10
    else $error("load_done without a load");

  property p_cfg_edge_only;
    @(posedge clk_sys) disable iff (srst)
      cfg_s && cfg_prev_q |-> !fire;
  endproperty
  a_cfg_edge_only: assert property (p_cfg_edge_only) // see RULE20
    else $error("load on cfg level instead of edge");

  c_frame: cover property (@(posedge clk_sys) disable iff (srst)
    fire && mode_s == XPSC_MODE_FRAME);
  c_addr: cover property (@(posedge clk_sys) disable iff (srst)
    fire && mode_s == XPSC_MODE_ADDR);
  c_dead_cfg: cover property (@(posedge clk_sys) disable iff (srst)
    cfg_rise && !pend_q);
  c_all_off: cover property (@(posedge clk_sys) disable iff (srst)
    done_q && oe_q == '0);

endmodule

// File: tb/xpsc_host.sv
`timescale 1ns/100ps

module xpsc_host
  import xpsc_pkg::*;
(
  // link pins towards the device
  output logic sclk,
  output logic cs_n,
  output logic din,
  // serial data back from the device
  input wire logic dout
);
  // ================================================================
  // state
  logic [47:0] rx;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    rx = '0;
  end

  // ================================================================
  // close a transfer
  task automatic close();
    #2;
    cs_n = 1'b1;  // raised while sclk low
    #2;
    sclk = 1'b1;  // one more rise after select
    #7.5;
    sclk = 1'b0;
    #7.5;
  endtask

  // ================================================================
  // shift n bits, bit 0 first; clock stands still outside frames
  task automatic send(input logic [47:0] data, input int n, input bit hold);
    cs_n = 1'b0;  // lowered with sclk low
    #6;  // select leads the first rise
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      #3;
      din = data[i];  // settles mid high phase
      #4.5;
      sclk = 1'b0;
      #7.5;
      rx = {dout, rx[47:1]};
      din = ~din;  // no stale level once the bit is done
    end
    if (!hold) begin
      close();
    end
  endtask

  // ================================================================
  // clock and data activity with select high
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      din = i[0];
      #7.5;
      sclk = 1'b0;
      #7.5;
    end
  endtask
endmodule

// File: tb/crosspoint_serial_control_tb.sv
`timescale 1ns/100ps

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
  mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module crosspoint_serial_control_tb
  import xpsc_pkg::*;
;
  // ================================================================
  // signals
  logic clk_sys;
  logic srst;
  logic cfg;
  logic mode;
  wire sclk;
  wire cs_n;
  wire din;
  wire dout;
  logic [31:0] out_sel;
  logic [7:0] out_oe;
  logic data_pending;
  logic load_done;
  logic link_armed;
  logic [31:0] e_sel;
  logic [7:0] e_oe;
  int mismatches;
  int tests_run;

  // ================================================================
  // instances
  xpsc_ctrl dut_u (
    .clk_sys(clk_sys),
    .srst(srst),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout(dout),
    .cfg(cfg),
    .mode(mode),
    .out_sel(out_sel),
    .out_oe(out_oe),
    .data_pending(data_pending),
    .load_done(load_done),
    .link_armed(link_armed)
  );

  xpsc_host host_u (
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout(dout)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ================================================================
  // helpers
  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // fixed window: load_done is a one-cycle pulse
  task automatic pulse_cfg(output bit seen);
    cfg = 1'b1;
    cyc(3);
    cfg = 1'b0;
    seen = (load_done === 1'b1);
    for (int i = 0; i < 10; i++) begin
      cyc(1);
      if (load_done === 1'b1) seen = 1'b1;
    end
  endtask

  function automatic logic [39:0] mk_frame(input logic [31:0] s,
      input logic [7:0] off);
    logic [39:0] f;
    for (int k = 0; k < 8; k++) begin
      f[5*k +: 5] = {off[k], s[4*k +: 4]};
    end
    return f;
  endfunction

  // ================================================================
  // scenarios
  task automatic t_reset();
    srst = 1'b1;
    cyc(3);
    srst = 1'b0;
    cyc(1);
    e_sel = '0;
    e_oe = '0;
    `CHK(out_sel, 32'h0000_0000)
    `CHK(out_oe, 8'h00)
    `CHK(data_pending, 1'b0)
    `CHK(load_done, 1'b0)
  endtask

  task automatic t_frame();
    bit seen;
    mode = 1'b0;
    e_sel = 32'hc197_0f33;
    e_oe = 8'hbd;
    cyc(3);
    host_u.send({8'h00, mk_frame(e_sel, ~e_oe)}, 40, 1'b1);
    cyc(3);
    `CHK(data_pending, 1'b1)
    `CHK(link_armed, 1'b1)
    `CHK(out_oe, 8'h00)
    pulse_cfg(seen);
    `CHK(seen, 1'b1)
    `CHK(out_sel, e_sel)
    `CHK(out_oe, e_oe)
    `CHK(data_pending, 1'b0)
    host_u.close();
    cyc(3);
    pulse_cfg(seen);
    `CHK(seen, 1'b0)
    `CHK(out_sel, e_sel)
  endtask

  task automatic t_addr();
    logic [7:0] w [2] = '{8'h4d, 8'h99};
    bit seen;
    mode = 1'b1;
    cyc(3);
    foreach (w[i]) begin
      host_u.send({40'h0, w[i]}, 8, 1'b0);
      cyc(3);
      pulse_cfg(seen);
      e_sel[4*w[i][2:0] +: 4] = w[i][6:3];
      e_oe[w[i][2:0]] = ~w[i][7];
      `CHK(seen, 1'b1)
      `CHK(out_sel, e_sel)
      `CHK(out_oe, e_oe)
    end
  endtask

  // eight extra bits ahead of the frame are pushed out again
  task automatic t_over();
    bit seen;
    mode = 1'b0;
    e_sel = 32'h5a5a_1e2d;
    e_oe = 8'h7e;
    cyc(3);
    host_u.send({mk_frame(e_sel, ~e_oe), 8'ha5}, 48, 1'b0);
    `CHK(host_u.rx[47:40], 8'ha5)
    cyc(3);
    pulse_cfg(seen);
    `CHK(out_sel, e_sel)
    `CHK(out_oe, e_oe)
  endtask

  task automatic t_noise();
    bit seen;
    host_u.noise(20);
    cyc(3);
    `CHK(link_armed, 1'b0)
    `CHK(data_pending, 1'b0)
    pulse_cfg(seen);
    `CHK(seen, 1'b0)
    `CHK(out_sel, e_sel)
  endtask

  // ================================================================
  // main sequence
  initial begin
    srst = 1'b1;
    cfg = 1'b0;
    mode = 1'b0;
    mismatches = 0;
    tests_run = 0;
    t_reset();
    t_frame();
    t_addr();
    t_over();
    t_noise();
    t_reset();
    end_sim();
  end

  // hang guard
  initial begin
    #1000000;
    mismatches++;
    end_sim();
  end
endmodule
